// File: src/amc_pkg.sv
// Shared constants and types for the asynchronous modem control block
package amc_pkg;
  // Register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LEVEL = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_INT_STAT = 8'h0c;
  localparam logic [7:0] OFS_INT_MASK = 8'h10;
  // Control register fields
  localparam int unsigned CTRL_SLOW_RATE_BIT = 0;
  localparam int unsigned CTRL_FW_UPGRADE_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // Level register fields: nominal level and carrier threshold, in dB steps
  localparam int unsigned LEVEL_NOM_LSB = 0;
  localparam int unsigned LEVEL_THR_LSB = 8;
  localparam logic [7:0] NOMINAL_RESET = 8'hc0;
  localparam logic [7:0] CD_THR_RESET = 8'h80;
  // Alarm entry depth and hysteresis, in dB
  localparam logic [8:0] ALARM_DROP_DB = 9'h00e;
  localparam logic [8:0] ALARM_HYST_DB = 9'h003;
  // Status register fields
  localparam int unsigned ST_SW_LSB = 0;
  localparam int unsigned ST_CTS_BIT = 10;
  localparam int unsigned ST_CD_BIT = 11;
  localparam int unsigned ST_ALARM_BIT = 12;
  localparam int unsigned ST_CFG_ERR_BIT = 13;
  localparam int unsigned ST_DSR_BIT = 14;
  // Interrupt bits
  localparam int unsigned IRQ_N = 4;
  localparam int unsigned IRQ_ALARM = 0;
  localparam int unsigned IRQ_CFG_ERR = 1;
  localparam int unsigned IRQ_CD_CHG = 2;
  localparam int unsigned IRQ_CTS_UP = 3;
  localparam logic [3:0] INT_RESET = 4'h0;
  // Timing
  localparam int unsigned CLK_KHZ = 250000;
  localparam int unsigned SLOW_UNIT_MS = 30;
  localparam int unsigned FAST_UNIT_MS = 10;
  localparam int unsigned FLASH_MS = 250;
  localparam int unsigned SLOW_UNIT_CYC = SLOW_UNIT_MS * CLK_KHZ;
  localparam int unsigned FAST_UNIT_CYC = FAST_UNIT_MS * CLK_KHZ;
  localparam int unsigned FLASH_CYC = FLASH_MS * CLK_KHZ;
  localparam int unsigned PRE_W = 26;
  // Input synchroniser: 10 switches, terminal RTS, terminal TD
  localparam int unsigned NSYNC = 12;
  localparam int unsigned SYNC_RTS = 10;
  localparam int unsigned SYNC_TD = 11;
  // Test pattern codes from switches 10 and 9
  localparam logic [1:0] PAT_NORMAL = 2'h0;
  localparam logic [1:0] PAT_ONE = 2'h1;
  localparam logic [1:0] PAT_ALT = 2'h2;
  localparam logic [1:0] PAT_ZERO = 2'h3;

  typedef enum logic [1:0] {
    AMC_CTS_IDLE = 2'b00,
    AMC_CTS_WAIT = 2'b01,
    AMC_CTS_READY = 2'b10
  } amc_cts_e;

  // Front indicators
  typedef struct packed {
    logic test;
    logic data_loop;
    logic line_loop;
    logic green;
    logic red;
    logic yellow;
  } amc_led_s;
endpackage

// File: src/amc_modem_ctrl.sv
// Control logic of an asynchronous programmable modem
//
// What this block does
// - Switch 1 on selects full duplex, off selects half duplex.
// - Delay code: switch 2 off adds 1, 3 off adds 2, 4 off adds 4.
// - RTS-to-CTS delay is 30 ms or 10 ms times code plus one.
// - Switch 5 on loops terminal data back to the terminal.
// - Switch 6 on loops the received line signal back to the line.
// - Switch 7 on or any test pattern forces RTS active; otherwise RTS follows the terminal RTS.
// - Switch 8 on blocks reception always; off blocks on carrier loss.
// - Switches 9/10 pick normal, constant 1, alternating, or constant 0.
// - Carrier detect is high only while level exceeds the threshold.
// - Steady red alarm at more than 14 dB below nominal, cleared with 3 dB hysteresis.
// - Green status when no alarm is present.
// - Flashing red status when the configuration is invalid.
// - Yellow status while firmware is being upgraded.
// - Test indicator on for any pattern or loop; separate loop indicators.
// - DSR high only while the modem works correctly.
`timescale 1ns/1ps
module amc_modem_ctrl
  import amc_pkg::*;
#(
  parameter int unsigned SLOW_CYC = SLOW_UNIT_CYC,
  parameter int unsigned FAST_CYC = FAST_UNIT_CYC,
  parameter int unsigned BLINK_CYC = FLASH_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  input wire logic [9:0] sw_pin,
  input wire logic rts_pin,
  input wire logic td_pin,
  input wire logic rx_line_data,
  input wire logic [7:0] rx_level,
  output logic tx_data,
  output logic rd_out,
  output logic cts,
  output logic dsr,
  output logic cd,
  output logic full_duplex,
  output amc_led_s led,
  output logic irq
);

  logic [NSYNC-1:0] s1, s2, s3, sv;
  logic [1:0] ctrl;
  logic [7:0] nominal, cd_thr;
  logic [IRQ_N-1:0] int_stat, int_mask, ev;
  logic alarm, cfg_err, cfg_err_d, alarm_d, cd_d, cts_d;
  amc_cts_e cts_st;
  logic [PRE_W-1:0] pre_cnt, blink_cnt;
  logic [3:0] step_cnt;
  logic blink, alt_bit;
  logic [2:0] dly_code;
  logic [1:0] pat;
  logic test_act, rts_eff, rx_block, unit_done;
  logic [PRE_W-1:0] unit_last;
  logic [8:0] lvl9, nom9;
  logic wr_ctrl, wr_level, wr_istat, wr_imask;
  logic [NSYNC-1:0] pin_raw;

  // Asynchronous inputs gathered in synchroniser order, so no index runs past a pin
  assign pin_raw = {td_pin, rts_pin, sw_pin};

  // Three-stage synchronisers; a level is taken once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          s1[gi] <= 1'b0;
          s2[gi] <= 1'b0;
          s3[gi] <= 1'b0;
          sv[gi] <= 1'b0;
        end else begin
          s1[gi] <= pin_raw[gi];
          s2[gi] <= s1[gi];
          s3[gi] <= s2[gi];
          if (s2[gi] == s3[gi]) begin
            sv[gi] <= s3[gi];
          end
        end
      end
    end
  endgenerate

  // Decoded configuration
  // delay code from inverted switches
  assign dly_code = {~sv[3], ~sv[2], ~sv[1]};
  // pattern code from switches 9 and 10
  assign pat = {sv[9], sv[8]};
  assign test_act = (pat != PAT_NORMAL);
  assign rts_eff = sv[6] | test_act | sv[SYNC_RTS];
  // permanent block or carrier loss; half duplex also blocks while sending
  assign rx_block = sv[7] | ~cd | (~full_duplex & rts_eff);
  // Both loops at once cannot be carried out
  assign cfg_err = sv[4] & sv[5];
  assign lvl9 = {1'b0, rx_level};
  assign nom9 = {1'b0, nominal};

  // Register write decode
  assign wr_ctrl = wr && (addr == OFS_CTRL);
  assign wr_level = wr && (addr == OFS_LEVEL);
  assign wr_istat = wr && (addr == OFS_INT_STAT);
  assign wr_imask = wr && (addr == OFS_INT_MASK);

  // Software control and level settings
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= CTRL_RESET;
      nominal <= NOMINAL_RESET;
      cd_thr <= CD_THR_RESET;
      int_mask <= INT_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl <= wdata[1:0];
      end
      if (wr_level) begin
        nominal <= wdata[LEVEL_NOM_LSB +: 8];
        cd_thr <= wdata[LEVEL_THR_LSB +: 8];
      end
      if (wr_imask) begin
        int_mask <= wdata[IRQ_N-1:0];
      end
    end
  end

  // Unit length of the RTS-to-CTS delay by rate class
  // 30 ms slow class, 10 ms fast class
  assign unit_last = ctrl[CTRL_SLOW_RATE_BIT] ? PRE_W'(SLOW_CYC - 1) : PRE_W'(FAST_CYC - 1);
  assign unit_done = (pre_cnt == unit_last);

  // RTS-to-CTS sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cts_st <= AMC_CTS_IDLE;
      pre_cnt <= '0;
      step_cnt <= 4'h0;
      cts <= 1'b0;
    end else begin
      unique case (cts_st)
        AMC_CTS_IDLE: begin
          pre_cnt <= '0;
          step_cnt <= 4'h0;
          cts <= 1'b0;
          if (rts_eff) begin
            cts_st <= AMC_CTS_WAIT;
          end
        end
        AMC_CTS_WAIT: begin
          if (!rts_eff) begin
            cts_st <= AMC_CTS_IDLE;
          end else if (unit_done) begin
            pre_cnt <= '0;
            if (step_cnt == {1'b0, dly_code}) begin
              cts_st <= AMC_CTS_READY;
              cts <= 1'b1;
            end else begin
              step_cnt <= step_cnt + 4'h1;
            end
          end else begin
            pre_cnt <= pre_cnt + PRE_W'(1);
          end
        end
        AMC_CTS_READY: begin
          if (!rts_eff) begin
            cts_st <= AMC_CTS_IDLE;
            cts <= 1'b0;
          end
        end
      endcase
    end
  end

  // Carrier detect and receive level alarm with hysteresis
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cd <= 1'b0;
      alarm <= 1'b0;
    end else begin
      cd <= (rx_level > cd_thr);
      // set when the drop exceeds 14 dB, clear 3 dB above that
      if (lvl9 + ALARM_DROP_DB < nom9) begin
        alarm <= 1'b1;
      end else if (lvl9 + ALARM_DROP_DB >= nom9 + ALARM_HYST_DB) begin
        alarm <= 1'b0;
      end
    end
  end

  // Line and terminal data paths
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_data <= 1'b1;
      rd_out <= 1'b1;
      alt_bit <= 1'b0;
      full_duplex <= 1'b0;
    end else begin
      alt_bit <= ~alt_bit;
      full_duplex <= sv[0];
      unique case (pat)
        PAT_ONE: tx_data <= 1'b1;
        PAT_ALT: tx_data <= alt_bit;
        PAT_ZERO: tx_data <= 1'b0;
        PAT_NORMAL: begin
          tx_data <= sv[5] ? rx_line_data : sv[SYNC_TD];
        end
      endcase
      if (sv[4]) begin
        rd_out <= sv[SYNC_TD];
      end else if (rx_block) begin
        rd_out <= 1'b1;
      end else begin
        rd_out <= rx_line_data;
      end
    end
  end

  // Indicator blink timebase
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      blink_cnt <= '0;
      blink <= 1'b0;
    end else if (blink_cnt == PRE_W'(BLINK_CYC - 1)) begin
      blink_cnt <= '0;
      blink <= ~blink;
    end else begin
      blink_cnt <= blink_cnt + PRE_W'(1);
    end
  end

  // Status indicators and DSR
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      led <= '0;
      dsr <= 1'b0;
    end else begin
      led.test <= test_act | sv[4] | sv[5];
      led.data_loop <= sv[4];
      led.line_loop <= sv[5];
      dsr <= ~cfg_err & ~ctrl[CTRL_FW_UPGRADE_BIT];
      if (ctrl[CTRL_FW_UPGRADE_BIT]) begin
        led.green <= 1'b0;
        led.red <= 1'b0;
        led.yellow <= 1'b1;
      end else if (cfg_err) begin
        led.green <= 1'b0;
        led.red <= blink;
        led.yellow <= 1'b0;
      end else begin
        led.green <= ~alarm;
        led.red <= alarm;
        led.yellow <= 1'b0;
      end
    end
  end

  // Event detection for interrupts
  assign ev[IRQ_ALARM] = alarm & ~alarm_d;
  assign ev[IRQ_CFG_ERR] = cfg_err & ~cfg_err_d;
  assign ev[IRQ_CD_CHG] = cd ^ cd_d;
  assign ev[IRQ_CTS_UP] = cts & ~cts_d;

  // Sticky status, write one to clear, a new event wins over the clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      alarm_d <= 1'b0;
      cfg_err_d <= 1'b0;
      cd_d <= 1'b0;
      cts_d <= 1'b0;
      int_stat <= INT_RESET;
      irq <= 1'b0;
    end else begin
      alarm_d <= alarm;
      cfg_err_d <= cfg_err;
      cd_d <= cd;
      cts_d <= cts;
      int_stat <= (int_stat & ~(wr_istat ? wdata[IRQ_N-1:0] : INT_RESET)) | ev;
      irq <= |(int_stat & int_mask);
    end
  end

  // Read data, valid in the cycle after the read strobe only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= '0;
    end else begin
      rdata <= '0;
      if (rd) begin
        unique case (addr)
          OFS_CTRL: rdata[1:0] <= ctrl;
          OFS_LEVEL: rdata[15:0] <= {cd_thr, nominal};
          OFS_STATUS: rdata[14:0] <= {dsr, cfg_err, alarm, cd, cts, sv[9:0]};
          OFS_INT_STAT: rdata[IRQ_N-1:0] <= int_stat;
          OFS_INT_MASK: rdata[IRQ_N-1:0] <= int_mask;
          default: rdata <= '0;
        endcase
      end
    end
  end

  // Checks
  a_duplex_mode: assert property (@(posedge clk) disable iff (!rst_b)
    1'b1 |=> full_duplex == $past(sv[0])) else $error("duplex mode not from switch 1");
  a_cts_delay: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(cts) |-> $past(cts_st) == AMC_CTS_WAIT && $past(step_cnt) == {1'b0, $past(dly_code)})
    else $error("CTS rose before the selected delay");
  a_cts_unit: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(cts) |-> $past(pre_cnt) == $past(unit_last)) else $error("CTS not on unit boundary");
  a_data_loop: assert property (@(posedge clk) disable iff (!rst_b)
    sv[4] |=> rd_out == $past(sv[SYNC_TD])) else $error("data loop not returning TD");
  a_line_loop: assert property (@(posedge clk) disable iff (!rst_b)
    sv[5] && pat == PAT_NORMAL |=> tx_data == $past(rx_line_data))
    else $error("line loop not returning line data");
  a_forced_rts: assert property (@(posedge clk) disable iff (!rst_b)
    sv[6] && cts_st == AMC_CTS_IDLE |=> cts_st == AMC_CTS_WAIT) else $error("forced RTS ignored");
  a_rx_block: assert property (@(posedge clk) disable iff (!rst_b)
    !sv[4] && (sv[7] || !cd) |=> rd_out) else $error("reception not blocked");
  a_pattern_out: assert property (@(posedge clk) disable iff (!rst_b)
    pat == PAT_ONE || pat == PAT_ZERO |=> tx_data == ($past(pat) == PAT_ONE))
    else $error("constant pattern wrong");
  a_test_rts: assert property (@(posedge clk) disable iff (!rst_b)
    test_act && cts_st == AMC_CTS_READY |=> cts) else $error("test lost internal RTS");
  a_carrier_det: assert property (@(posedge clk) disable iff (!rst_b)
    1'b1 |=> cd == ($past(rx_level) > $past(cd_thr))) else $error("carrier detect wrong");
  a_alarm_set: assert property (@(posedge clk) disable iff (!rst_b)
    lvl9 + ALARM_DROP_DB < nom9 |=> alarm) else $error("alarm not raised");
  a_alarm_hold: assert property (@(posedge clk) disable iff (!rst_b)
    alarm && lvl9 + ALARM_DROP_DB < nom9 + ALARM_HYST_DB |=> alarm) else $error("no hysteresis");
  a_status_green: assert property (@(posedge clk) disable iff (!rst_b)
    !alarm && !cfg_err && !ctrl[1] |=> led.green && !led.red) else $error("green not shown");
  a_cfg_flash: assert property (@(posedge clk) disable iff (!rst_b)
    cfg_err && !ctrl[1] |=> !led.green && led.red == $past(blink)) else $error("no red flash");
  a_upgrade_led: assert property (@(posedge clk) disable iff (!rst_b)
    ctrl[1] |=> led.yellow && !led.green) else $error("upgrade not yellow");
  a_test_led: assert property (@(posedge clk) disable iff (!rst_b)
    test_act || sv[4] || sv[5] |=> led.test) else $error("test indicator off");
  a_dsr_ok: assert property (@(posedge clk) disable iff (!rst_b)
    cfg_err || ctrl[1] |=> !dsr) else $error("DSR high while faulty");
  a_cts_drop: assert property (@(posedge clk) disable iff (!rst_b)
    !rts_eff |=> !cts) else $error("CTS held without RTS");
  a_alt_pattern: assert property (@(posedge clk) disable iff (!rst_b)
    pat == PAT_ALT && $past(pat) == PAT_ALT |=> tx_data != $past(tx_data))
    else $error("alternating pattern stalled");
  a_rx_pass: assert property (@(posedge clk) disable iff (!rst_b)
    !sv[4] && !rx_block |=> rd_out == $past(rx_line_data)) else $error("reception blocked");
  a_loop_leds: assert property (@(posedge clk) disable iff (!rst_b)
    1'b1 |=> led.data_loop == $past(sv[4]) && led.line_loop == $past(sv[5]))
    else $error("loop indicator wrong");
  a_dsr_good: assert property (@(posedge clk) disable iff (!rst_b)
    !cfg_err && !ctrl[CTRL_FW_UPGRADE_BIT] |=> dsr) else $error("DSR low while working");

endmodule

// File: verification/amc_dte_model.sv
// Terminal-side model: raises RTS on demand and sends data once cleared
`timescale 1ns/1ps
module amc_dte_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic want,
  input wire logic td_bit,
  input wire logic cts,
  output logic rts_pin,
  output logic td_pin
);
  // RTS follows demand; data idles at mark while waiting for clearance
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rts_pin <= 1'b0;
      td_pin <= 1'b1;
    end else begin
      rts_pin <= want;
      td_pin <= (want && !cts) ? 1'b1 : td_bit;
    end
  end
endmodule

// File: verification/testbench.sv
// Self-checking bench for the modem control block
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  import amc_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, want = 1'b0, td_bit = 1'b1;
  logic rx_line_data = 1'b0, v, prev;
  logic [7:0] addr = 8'h00, rx_level = 8'hc8;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [9:0] sw_pin = 10'h001;
  logic rts_pin, td_pin, tx_data, rd_out, cts, dsr, cd, full_duplex, irq;
  amc_led_s led;
  int fail_count = 0, checks = 0, cycles = 0, n, ones;

  amc_modem_ctrl #(.SLOW_CYC(20), .FAST_CYC(10), .BLINK_CYC(8)) i_amc_modem_ctrl (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .sw_pin(sw_pin), .rts_pin(rts_pin), .td_pin(td_pin),
    .rx_line_data(rx_line_data), .rx_level(rx_level), .tx_data(tx_data),
    .rd_out(rd_out), .cts(cts), .dsr(dsr), .cd(cd), .full_duplex(full_duplex),
    .led(led), .irq(irq));
  amc_dte_model i_amc_dte_model (.clk(clk), .rst_b(rst_b), .want(want),
    .td_bit(td_bit), .cts(cts), .rts_pin(rts_pin), .td_pin(td_pin));

  // Clock of 4 ns
  always #2 clk = ~clk;

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      wrap_up();
    end
  end

  // Shortest wait for clear to send, scaled units
  function automatic int exp_delay(input int code, input int slow);
    return (code + 1) * (slow ? 20 : 10);
  endfunction

  task automatic wrap_up();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic set_sw(input logic [9:0] s);
    @(posedge clk);
    sw_pin <= s;
    repeat (8) @(posedge clk);
    #1;
  endtask

  // Raise RTS and count cycles until clear to send
  task automatic measure(output int k);
    @(posedge clk);
    want <= 1'b1;
    k = 0;
    while (cts !== 1'b1 && k < 400) begin
      @(posedge clk);
      #1 k++;
    end
  endtask

  task automatic wait_cts();
    n = 0;
    while (cts !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1 n++;
    end
  endtask

  // Main sequence
  initial begin
    void'($urandom(74565));
    @(posedge clk);
    #1;
    `CHK({tx_data, rd_out, cts, dsr}, 4'hc)
    repeat (9) @(posedge clk);
    rst_b <= 1'b1;
    rd_reg(OFS_CTRL, rv);
    `CHK(rv, 32'h0)
    rd_reg(OFS_LEVEL, rv);
    `CHK(rv, 32'h80c0)
    rd_reg(OFS_INT_MASK, rv);
    `CHK(rv, 32'h0)
    rd_reg(8'h14, rv);
    `CHK(rv, 32'h0)
    set_sw(10'h000);
    `CHK(full_duplex, 1'b0)
    set_sw(10'h001);
    `CHK(full_duplex, 1'b1)
    `CHK({dsr, led.green}, 2'h3)
    for (int s = 0; s < 2; s++) begin
      wr_reg(OFS_CTRL, s);
      for (int c = 0; c < 8; c++) begin
        set_sw({6'h00, ~c[2:0], 1'b1});
        measure(n);
        `CHK(n >= exp_delay(c, s) && n <= exp_delay(c, s) + 10, 1'b1)
        rd_reg(OFS_STATUS, rv);
        `CHK({rv[ST_CTS_BIT], rv[9:0]}, {1'b1, 6'h00, ~c[2:0], 1'b1})
        @(posedge clk);
        want <= 1'b0;
        repeat (9) @(posedge clk);
        #1;
        `CHK(cts, 1'b0)
      end
    end
    // Abort mid-wait, then a full fresh count
    @(posedge clk);
    want <= 1'b1;
    repeat (40) @(posedge clk);
    want <= 1'b0;
    #1;
    `CHK(cts, 1'b0)
    repeat (12) @(posedge clk);
    measure(n);
    `CHK(n >= exp_delay(7, 1) && n <= exp_delay(7, 1) + 10, 1'b1)
    @(posedge clk);
    want <= 1'b0;
    wr_reg(OFS_CTRL, 32'h0);
    set_sw(10'h041);
    wait_cts();
    `CHK(cts, 1'b1)
    // Every pattern code; code 0 sends terminal data
    for (int p = 0; p < 4; p++) begin
      @(posedge clk);
      td_bit <= 1'b0;
      set_sw({p[1:0], 8'h01});
      if (p != 0) wait_cts();
      `CHK({led.test, cts}, {p != 0, p != 0})
      prev = tx_data;
      @(posedge clk);
      #1;
      `CHK(tx_data, (p == 0) ? 1'b0 : (p == 2) ? ~prev : (p == 1))
    end
    set_sw(10'h011);
    for (int b = 0; b < 2; b++) begin
      @(posedge clk);
      td_bit <= b[0];
      repeat (8) @(posedge clk);
      #1;
      `CHK({rd_out, led.data_loop, led.test}, {b[0], 2'h3})
    end
    set_sw(10'h021);
    `CHK({led.line_loop, led.data_loop}, 2'h2)
    for (int i = 0; i < 16; i++) begin
      v = 1'($urandom);
      @(posedge clk);
      rx_line_data <= v;
      @(posedge clk);
      #1;
      `CHK(tx_data, v)
    end
    set_sw(10'h031);
    ones = 0;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      #1 ones += int'(led.red === 1'b1);
    end
    `CHK(ones > 0 && ones < 40, 1'b1)
    `CHK({dsr, led.green}, 2'h0)
    // Reception blocking, carrier present then lost
    @(posedge clk);
    rx_level <= 8'h90;
    set_sw(10'h081);
    @(posedge clk);
    rx_line_data <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    `CHK(rd_out, 1'b1)
    set_sw(10'h001);
    `CHK(rd_out, 1'b0)
    @(posedge clk);
    rx_level <= 8'h10;
    repeat (3) @(posedge clk);
    #1;
    `CHK({cd, rd_out}, 2'h1)
    for (int i = 0; i < 22; i++) begin
      @(posedge clk);
      rx_level <= (i == 0) ? 8'h80 : (i == 1) ? 8'h81 : 8'($urandom);
      repeat (3) @(posedge clk);
      #1;
      `CHK(cd, rx_level > 8'h80)
    end
    // Alarm entry and hysteresis, raised on the interrupt line
    @(posedge clk);
    rx_level <= 8'hc8;
    wr_reg(OFS_INT_MASK, 32'h1 << IRQ_ALARM);
    wr_reg(OFS_INT_STAT, 32'hf);
    rx_level <= 8'd178;
    repeat (4) @(posedge clk);
    #1;
    `CHK({led.green, led.red, irq}, 3'h4)
    @(posedge clk);
    rx_level <= 8'd177;
    repeat (4) @(posedge clk);
    #1;
    `CHK({led.green, led.red, irq}, 3'h3)
    @(posedge clk);
    rx_level <= 8'd180;
    repeat (4) @(posedge clk);
    #1;
    `CHK(led.red, 1'b1)
    @(posedge clk);
    rx_level <= 8'd181;
    repeat (4) @(posedge clk);
    #1;
    `CHK({led.green, led.red, irq}, 3'h5)
    rd_reg(OFS_INT_STAT, rv);
    `CHK(rv[IRQ_ALARM], 1'b1)
    wr_reg(OFS_INT_STAT, 32'h1);
    repeat (3) @(posedge clk);
    #1;
    `CHK(irq, 1'b0)
    wr_reg(OFS_INT_MASK, 32'h0);
    rx_level <= 8'd170;
    repeat (4) @(posedge clk);
    #1;
    `CHK({led.red, irq}, 2'h2)
    wr_reg(OFS_CTRL, 32'h2);
    repeat (3) @(posedge clk);
    #1;
    `CHK({led.yellow, dsr}, 2'h2)
    wr_reg(OFS_CTRL, 32'h0);
    repeat (3) @(posedge clk);
    #1;
    `CHK({led.yellow, dsr}, 2'h1)
    wrap_up();
  end
endmodule
